// ===== verilog/serial_tx_top.sv
// Serial transmit channel: APB registers, frame sequencer and pin drive
// Assumes an APB master on clock and a remote asynchronous receiver on txd
////////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choice: the APB slave port.
module serial_tx_top
	import serial_tx_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             txd,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe
);
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] divider;
		logic [7:0] ctrl;
		logic [7:0] thr;
		logic       mpbt;
		tx_state_t  txs;
		logic [7:0] shift;
		logic [2:0] cnt;
		logic       par;
		logic       stop_left;
		logic       txd;
		logic       sck_oe;
		logic       sck_out;
	} top_state_t;

	localparam top_state_t RESET_STATE = '{
		mode: RST_MODE,
		divider: RST_DIVIDER,
		ctrl: RST_CTRL,
		thr: RST_THR,
		mpbt: RST_MPBT,
		txs: ST_IDLE,
		shift: 8'h00,
		cnt: 3'h0,
		par: 1'h0,
		stop_left: 1'h0,
		txd: RST_TXD,
		sck_oe: 1'h0,
		sck_out: 1'h0
	};

	top_state_t r, n;
	logic       wr;
	logic       sel_mode;
	logic       sel_div;
	logic       sel_ctrl;
	logic       sel_thr;
	logic       sel_sts;
	logic       hit;
	logic       enable;
	logic       ready;
	logic       load;
	logic       frame_end;
	logic       sts_clr;
	logic       tbe;
	logic       tdone;
	logic [7:0] data_bits;
	logic [7:0] status;

	baud_if bi ();

	////////////////////////////////////////////////////////////////////////////
	// APB decode; every access completes in its first access cycle
	assign sel_mode = paddr == ADDR_MODE;
	assign sel_div  = paddr == ADDR_DIVIDER;
	assign sel_ctrl = paddr == ADDR_CTRL;
	assign sel_thr  = paddr == ADDR_THR;
	assign sel_sts  = paddr == ADDR_STATUS;
	assign hit      = sel_mode | sel_div | sel_ctrl | sel_thr | sel_sts;
	assign wr       = psel & penable & pwrite & hit;
	assign pready   = 1'h1;
	assign pslverr  = psel & penable & ~hit;

	assign status = {tbe, 4'h0, tdone, 1'h0, r.mpbt};

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (sel_mode)
				prdata[7:0] = r.mode;
			if (sel_div)
				prdata[7:0] = r.divider;
			if (sel_ctrl)
				prdata[7:0] = r.ctrl;
			if (sel_thr)
				prdata[7:0] = r.thr;
			if (sel_sts)
				prdata[7:0] = status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer control between holding register and shifter
	// Clocked synchronous mode is not built; the transmitter then stays idle
	assign enable = r.ctrl[B_TX_ON] & ~r.mode[B_SYNC];
	assign ready = (r.txs == ST_IDLE)
		| (r.txs == ST_STOP & bi.bit_tick & ~r.stop_left);
	assign load = enable & ~tbe & ready;
	assign frame_end = enable & (r.txs == ST_STOP) & bi.bit_tick
		& ~r.stop_left;
	// Writing 0 to buffer-empty after it reads 1 hands the byte over
	assign sts_clr = wr & sel_sts & ~pwdata[B_TBE] & tbe;
	assign data_bits = r.mode[B_CHAR_LEN]
		? {1'h0, r.thr[6:0]} : r.thr;

	sticky_flag #(
		.RST_VAL (RST_TBE)
	) u_tbe (
		.clock (clock),
		.rst_n (rst_n),
		.set   (load | ~r.ctrl[B_TX_ON]),
		.clr   (sts_clr),
		.flag  (tbe)
	);

	sticky_flag #(
		.RST_VAL (RST_TDONE)
	) u_tdone (
		.clock (clock),
		.rst_n (rst_n),
		.set   ((frame_end & ~load) | ~r.ctrl[B_TX_ON]),
		.clr   (load | sts_clr),
		.flag  (tdone)
	);

	assign bi.divider = r.divider;
	assign bi.prescale_exp = r.mode[1:0];
	// A frame from idle restarts the generator so the start bit is whole
	assign bi.restart = load & (r.txs == ST_IDLE);

	baud_tick_gen u_baud (
		.clock (clock),
		.rst_n (rst_n),
		.bi    (bi.gen)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register writes and frame sequencer
	always_comb begin
		n = r;
		if (wr && sel_mode)
			n.mode = pwdata[7:0];
		if (wr && sel_div)
			n.divider = pwdata[7:0];
		if (wr && sel_ctrl)
			n.ctrl = pwdata[7:0];
		if (wr && sel_thr)
			n.thr = pwdata[7:0];
		if (wr && sel_sts)
			n.mpbt = pwdata[B_MPBT];
		if (!enable) begin
			n.txs = ST_IDLE;
			n.txd = 1'h1;
			n.stop_left = 1'h0;
		end else if (load) begin
			n.txs = ST_START;
			n.txd = 1'h0;
			n.shift = data_bits;
			n.cnt = r.mode[B_CHAR_LEN] ? 3'h6 : 3'h7;
			n.par = r.mode[B_PAR_ODD] ^ (^data_bits);
			n.stop_left = r.mode[B_STOP2];
		end else if (bi.bit_tick) begin
			unique case (r.txs)
				ST_IDLE: begin
					n.txd = 1'h1;
				end
				ST_START: begin
					n.txs = ST_DATA;
					n.txd = r.shift[0];
				end
				ST_DATA: begin
					if (r.cnt == 3'h0) begin
						if (r.mode[B_MULTI]) begin
							n.txs = ST_MPB;
							n.txd = r.mpbt;
						end else if (r.mode[B_PAR_ON]) begin
							n.txs = ST_PAR;
							n.txd = r.par;
						end else begin
							n.txs = ST_STOP;
							n.txd = 1'h1;
						end
					end else begin
						n.shift = {1'h0, r.shift[7:1]};
						n.txd = r.shift[1];
						n.cnt = r.cnt - 3'h1;
					end
				end
				ST_PAR, ST_MPB: begin
					n.txs = ST_STOP;
					n.txd = 1'h1;
				end
				ST_STOP: begin
					if (r.stop_left) begin
						n.stop_left = 1'h0;
					end else begin
						n.txs = ST_IDLE;
						n.txd = 1'h1;
					end
				end
			endcase
		end
		// Internal clock only; pin is general I/O unless select is 01
		n.sck_oe = ~r.mode[B_SYNC] & (r.ctrl[1:0] == SCK_OUT_SEL);
		n.sck_out = bi.clk_phase;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			r <= RESET_STATE;
		else
			r <= n;
	end

	assign txd = r.txd;
	assign serial_clock_pin_out = r.sck_out;
	assign serial_clock_pin_oe = r.sck_oe;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_load_idle;
		load && r.txs == ST_IDLE;
	endsequence

	sequence s_start_held;
		!txd ##1 !txd;
	endsequence

	sequence s_leave_start;
		r.txs == ST_START && bi.bit_tick && enable && !load;
	endsequence

	chk_load_gate: assert property (
		load |-> !tbe && r.ctrl[B_TX_ON] && !r.mode[B_SYNC])
		else $error("byte moved while not allowed");

	chk_tbe_on_load: assert property (
		load |=> tbe && r.txs == ST_START)
		else $error("buffer-empty not set after move");

	chk_tbe_reads: assert property (
		psel && !pwrite && sel_sts |-> prdata[B_TBE] == tbe)
		else $error("status bit 7 does not show buffer-empty");

	chk_done_clear: assert property (
		load |=> !tdone ##0 !prdata[B_TDONE] || !sel_sts)
		else $error("transmit-end still set while sending");

	chk_tail_done: assert property (
		frame_end && !load |=> tdone && txd && r.txs == ST_IDLE)
		else $error("frame end without transmit-end");

	chk_back_to_back: assert property (
		frame_end && load |=> r.txs == ST_START && !txd)
		else $error("gap between back-to-back frames");

	chk_start_low: assert property (
		s_load_idle |=> s_start_held)
		else $error("start bit not low");

	chk_lsb_first: assert property (
		s_leave_start |=> txd == $past(r.shift[0]))
		else $error("first data bit is not the LSB");

	chk_data_count: assert property (
		load |=> r.cnt == ($past(r.mode[B_CHAR_LEN]) ? 3'h6 : 3'h7))
		else $error("wrong number of data bits");

	chk_parity_val: assert property (
		load |=> r.par == ($past(r.mode[B_PAR_ODD]) ^ (^$past(data_bits))))
		else $error("parity value wrong");

	chk_parity_line: assert property (
		r.txs == ST_PAR |-> txd == r.par && r.mode[B_PAR_ON])
		else $error("parity bit not on the line");

	chk_stop_high: assert property (
		r.txs == ST_STOP |-> txd)
		else $error("stop bit not high");

	chk_tx_off: assert property (
		!r.ctrl[B_TX_ON] |=> r.txs == ST_IDLE && txd)
		else $error("transmitter active while disabled");

	chk_sync_quiet: assert property (
		r.mode[B_SYNC] |=> r.txs == ST_IDLE && txd)
		else $error("frame sent in synchronous mode");

	chk_sck_gpio: assert property (
		r.ctrl[1:0] == 2'h0 |=> !serial_clock_pin_oe)
		else $error("serial clock pin driven as general I/O");

	chk_thr_write: assert property (
		wr && sel_thr |=> r.thr == $past(pwdata[7:0]))
		else $error("holding register write lost");

endmodule : serial_tx_top

// ===== verilog/serial_tx_pkg.sv
// Constants, register map and types of the serial transmit channel
// Assumes one system clock and a 32-bit APB master reaching the registers
////////////////////////////////////////////////////////////////////////////////
package serial_tx_pkg;
	localparam logic [23:0] IDX_MODE    = 24'hFFFF88;
	localparam logic [23:0] IDX_DIVIDER = 24'hFFFF89;
	localparam logic [23:0] IDX_CTRL    = 24'hFFFF8A;
	localparam logic [23:0] IDX_THR     = 24'hFFFF8B;
	localparam logic [23:0] IDX_STATUS  = 24'hFFFF8C;
	localparam logic [31:0] ADDR_MODE    = {6'h00, IDX_MODE, 2'h0};
	localparam logic [31:0] ADDR_DIVIDER = {6'h00, IDX_DIVIDER, 2'h0};
	localparam logic [31:0] ADDR_CTRL    = {6'h00, IDX_CTRL, 2'h0};
	localparam logic [31:0] ADDR_THR     = {6'h00, IDX_THR, 2'h0};
	localparam logic [31:0] ADDR_STATUS  = {6'h00, IDX_STATUS, 2'h0};
	localparam int B_SYNC     = 7;
	localparam int B_CHAR_LEN = 6;
	localparam int B_PAR_ON   = 5;
	localparam int B_PAR_ODD  = 4;
	localparam int B_STOP2    = 3;
	localparam int B_MULTI    = 2;
	localparam int B_TX_ON    = 5;
	localparam int B_TBE      = 7;
	localparam int B_TDONE    = 2;
	localparam int B_MPBT     = 0;
	localparam logic [7:0] RST_MODE    = 8'h00;
	localparam logic [7:0] RST_DIVIDER = 8'hFF;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_THR     = 8'hFF;
	localparam logic       RST_TBE     = 1'h1;
	localparam logic       RST_TDONE   = 1'h1;
	localparam logic       RST_MPBT    = 1'h0;
	localparam logic       RST_TXD     = 1'h1;
	// Clock cycles per half bit at prescale exponent 0 and divider 0
	localparam logic [10:0] HALF_BIT_BASE = 11'h010;
	localparam logic [1:0]  SCK_OUT_SEL   = 2'h1;
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_MPB, ST_STOP
	} tx_state_t;
endpackage : serial_tx_pkg

// ===== verilog/baud_if.sv
// Carrier between the frame sequencer and the baud tick generator
// Assumes both ends run on the same system clock
////////////////////////////////////////////////////////////////////////////////
interface baud_if;
	logic [7:0] divider;
	logic [1:0] prescale_exp;
	logic       restart;
	logic       bit_tick;
	logic       clk_phase;
	modport ctrl (output divider, prescale_exp, restart,
		input bit_tick, clk_phase);
	modport gen (input divider, prescale_exp, restart,
		output bit_tick, clk_phase);
endinterface : baud_if

// ===== verilog/sticky_flag.sv
// One status flag that hardware sets and software clears
// Assumes set and clr come from logic on the same clock
////////////////////////////////////////////////////////////////////////////////
module sticky_flag #(
	parameter logic RST_VAL = 1'h0
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);
	typedef struct packed {
		logic f;
	} flag_state_t;
	flag_state_t r, n;
	always_comb begin
		n = r;
		if (clr)
			n.f = 1'h0;
		// Set wins over a clear in the same cycle
		if (set)
			n.f = 1'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			r <= '{f: RST_VAL};
		else
			r <= n;
	end
	assign flag = r.f;
	chk_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
		set |=> flag) else $error("flag lost a set");
endmodule : sticky_flag

// ===== verilog/baud_tick_gen.sv
// Bit-rate generator: prescaler plus 8-bit divider, one tick per bit
// Assumes divider and exponent are held stable while a frame is sent
////////////////////////////////////////////////////////////////////////////////
module baud_tick_gen
	import serial_tx_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	baud_if.gen       bi
);
	typedef struct packed {
		logic [10:0] pre;
		logic [7:0]  div;
		logic        phase;
	} baud_state_t;
	baud_state_t r, n;
	logic [10:0] pre_last;
	logic        half_tick;
	logic [18:0] gap_r;
	logic [18:0] period;
	logic [9:0]  cfg_r;
	logic        gap_ok_r;
	always_comb begin
		pre_last = (HALF_BIT_BASE << {bi.prescale_exp, 1'h0}) - 11'h001;
		n = r;
		half_tick = 1'h0;
		if (bi.restart) begin
			n = '0;
		end else if (r.pre < pre_last) begin
			n.pre = r.pre + 11'h001;
		end else begin
			n.pre = '0;
			if (r.div < bi.divider) begin
				n.div = r.div + 8'h01;
			end else begin
				n.div = '0;
				half_tick = 1'h1;
				n.phase = ~r.phase;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end
	assign bi.bit_tick = half_tick & r.phase;
	assign bi.clk_phase = r.phase;
	////////////////////////////////////////////////////////////////////////////
	// Bit period check: 32 * 4^n * (divider + 1) cycles between ticks
	assign period = 19'({11'h000, bi.divider} + 19'h00001)
		<< ({2'h0, bi.prescale_exp, 1'h0} + 4'h5);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap_r <= '0;
			gap_ok_r <= 1'h0;
			cfg_r <= '0;
		end else begin
			cfg_r <= {bi.prescale_exp, bi.divider};
			gap_r <= (bi.restart || bi.bit_tick) ? '0 : gap_r + 19'h00001;
			if (bi.restart || bi.bit_tick)
				gap_ok_r <= 1'h1;
			if (cfg_r != {bi.prescale_exp, bi.divider})
				gap_ok_r <= 1'h0;
		end
	end
	chk_bit_period: assert property (
		@(posedge clock) disable iff (!rst_n)
		bi.bit_tick && gap_ok_r && cfg_r == {bi.prescale_exp, bi.divider}
		|-> gap_r == period - 19'h00001) else $error("bit period wrong");
endmodule : baud_tick_gen

// ===== dv/serial_rx_model.sv
// Behavioural remote asynchronous receiver listening on the serial line
// Assumes the bench sets format and bit length before each frame starts
////////////////////////////////////////////////////////////////////////////////
module serial_rx_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        txd,
	input  wire logic [31:0] bit_cycles,
	input  wire logic [3:0]  data_bits,
	input  wire logic        extra_on,
	input  wire logic [1:0]  stop_bits,
	output logic      [7:0]  rx_data,
	output logic             rx_extra,
	output logic             rx_stop_ok,
	output int               rx_count,
	output time              rx_start
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] shift;

	task automatic wait_bit(input logic [31:0] n);
		repeat (n) @(posedge clock);
	endtask : wait_bit

	initial begin
		rx_data = 8'h00;
		rx_extra = 1'b0;
		rx_stop_ok = 1'b0;
		rx_count = 0;
		rx_start = 0;
		wait (rst_n === 1'b1);
		forever begin
			@(negedge txd);
			rx_start = $time;
			// Sample every bit after the start bit in its middle
			wait_bit(bit_cycles >> 1);
			shift = 8'h00;
			for (int i = 0; i < data_bits; i++) begin
				wait_bit(bit_cycles);
				shift[i] = txd;
			end
			if (extra_on) begin
				wait_bit(bit_cycles);
				rx_extra = txd;
			end
			rx_stop_ok = 1'b1;
			for (int i = 0; i < stop_bits; i++) begin
				wait_bit(bit_cycles);
				rx_stop_ok = rx_stop_ok & txd;
			end
			rx_data = shift;
			rx_count++;
		end
	end
endmodule : serial_rx_model

// ===== dv/test_async_serial_transmitter.sv
// Self-checking bench for the serial transmit channel over APB
// Assumes a behavioural receiver on txd and a 20 MHz system clock
////////////////////////////////////////////////////////////////////////////////
module test_async_serial_transmitter
	import serial_tx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 80000;
	localparam logic [7:0] TMODE [7] = '{8'h00, 8'h40, 8'h20, 8'h38,
		8'h70, 8'h04, 8'h01};
	localparam logic [7:0] TDATA [7] = '{8'hA5, 8'hD3, 8'h5A, 8'h71,
		8'h2C, 8'h96, 8'h3C};
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h00000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        txd;
	logic        serial_clock_pin_oe;
	logic        sck_out;
	logic [31:0] m_bitc = 32'h00000020;
	logic [3:0]  m_nbits = 4'h8;
	logic        m_extra = 1'b0;
	logic [1:0]  m_stops = 2'h1;
	logic [7:0]  rx_data;
	logic        rx_extra;
	logic        rx_stop_ok;
	int          rx_count;
	time         rx_start;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #25 clock = ~clock;

	serial_tx_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
		.serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe(serial_clock_pin_oe));

	serial_rx_model rx (.clock(clock), .rst_n(rst_n), .txd(txd),
		.bit_cycles(m_bitc), .data_bits(m_nbits), .extra_on(m_extra),
		.stop_bits(m_stops), .rx_data(rx_data), .rx_extra(rx_extra),
		.rx_stop_ok(rx_stop_ok), .rx_count(rx_count), .rx_start(rx_start));

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			final_report;
		end
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic apb(input logic wr, input logic [31:0] addr,
		input logic [7:0] wdata, output logic [31:0] rdata, output logic err);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h000000, wdata};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [31:0] addr, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, addr, d, r, e);
	endtask : wr

	task automatic check_reg(input logic [31:0] addr, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, addr, 8'h00, r, e);
		check_val(r, exp);
	endtask : check_reg

	task automatic set_fmt(input logic [7:0] mode, input logic [7:0] div);
		wr(ADDR_MODE, mode);
		wr(ADDR_DIVIDER, div);
		m_bitc = (32'h00000020 << (2 * mode[1:0])) * (div + 1);
		m_nbits = mode[6] ? 4'h7 : 4'h8;
		m_extra = mode[5] | mode[2];
		m_stops = mode[3] ? 2'h2 : 2'h1;
	endtask : set_fmt

	task automatic send(input logic [7:0] d, input logic mp);
		logic [31:0] r;
		logic        e;
		do apb(1'b0, ADDR_STATUS, 8'h00, r, e); while (r[7] !== 1'b1);
		wr(ADDR_THR, d);
		wr(ADDR_STATUS, {7'h00, mp});
	endtask : send

	task automatic one_frame(input logic [7:0] mode, input logic [7:0] d,
		input logic mp);
		logic [7:0] sent;
		int         c;
		c = rx_count;
		set_fmt(mode, 8'h00);
		sent = mode[6] ? {1'b0, d[6:0]} : d;
		send(d, mp);
		check_reg(ADDR_STATUS, 32'h00000080 | 32'(mp));
		while (rx_count <= c) @(posedge clock);
		check_val({24'h000000, rx_data}, {24'h000000, sent});
		if (m_extra) begin
			check_val({31'h0, rx_extra},
				{31'h0, mode[2] ? mp : ^sent ^ mode[4]});
		end
		check_val({31'h0, rx_stop_ok}, 32'h1);
		repeat (m_bitc) @(posedge clock);
		check_reg(ADDR_STATUS, 32'h00000084 | 32'(mp));
		check_val({31'h0, txd}, 32'h1);
	endtask : one_frame

	task automatic b2b(input logic [7:0] mode, input logic [7:0] div,
		input logic [7:0] d0, input logic [7:0] d1);
		time t0;
		int  c;
		c = rx_count;
		set_fmt(mode, div);
		send(d0, 1'b0);
		send(d1, 1'b0);
		while (rx_count <= c) @(posedge clock);
		t0 = rx_start;
		while (rx_count <= c + 1) @(posedge clock);
		check_val(32'((rx_start - t0) / 50),
			m_bitc * (1 + m_nbits + m_extra + m_stops));
		check_val({24'h000000, rx_data}, {24'h000000, d1});
	endtask : b2b

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic        e;
		int          c;
		logic        s0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		check_reg(ADDR_MODE, 32'h00000000);
		check_reg(ADDR_DIVIDER, {24'h000000, RST_DIVIDER});
		check_reg(ADDR_CTRL, 32'h00000000);
		check_reg(ADDR_THR, 32'h000000FF);
		check_reg(ADDR_STATUS, 32'h00000084);
		wr(ADDR_DIVIDER, 8'h5A);
		check_reg(ADDR_DIVIDER, 32'h0000005A);
		apb(1'b0, ADDR_STATUS + 32'h4, 8'h00, r, e);
		check_val({31'h0, e}, 32'h1);
		check_val(r, 32'h00000000);
		$display("test registers done");
		wr(ADDR_CTRL, 8'h20);
		check_val({31'h0, serial_clock_pin_oe}, 32'h0);
		for (int i = 0; i < 7; i++) begin
			one_frame(TMODE[i], TDATA[i], TMODE[i][2]);
		end
		$display("test formats done");
		b2b(8'h09, 8'h01, 8'h81, 8'h7E);
		b2b(8'h00, 8'h0C, 8'h0F, 8'hF0);
		$display("test back to back done");
		c = rx_count;
		wr(ADDR_MODE, 8'h80);
		wr(ADDR_THR, 8'h33);
		wr(ADDR_STATUS, 8'h00);
		repeat (1000) @(posedge clock);
		check_val(32'(rx_count), 32'(c));
		check_val({31'h0, txd}, 32'h1);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		repeat (1000) @(posedge clock);
		check_val(32'(rx_count), 32'(c));
		check_reg(ADDR_STATUS, 32'h00000084);
		$display("test refusals done");
		wr(ADDR_CTRL, 8'h01);
		repeat (2) @(posedge clock);
		check_val({31'h0, serial_clock_pin_oe}, 32'h1);
		s0 = sck_out;
		repeat (m_bitc >> 1) @(posedge clock);
		check_val({31'h0, sck_out}, {31'h0, ~s0});
		wr(ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clock);
		check_val({31'h0, serial_clock_pin_oe}, 32'h0);
		$display("test clock pin done");
		final_report;
	end
endmodule : test_async_serial_transmitter
